// [rtl/pfc_guard_pkg.sv]
// constants, carriers and register map of the pfc mode and current guard
// assumes one 40 MHz clock and a synchronous active-high reset
// How it works
// - cycle is on-time plus demag, timed
// - eight long cycles over 112% enter continuous
// - no eight-run within 360 ms exits continuous
// - forced option holds continuous mode always
// - long cycle needs 50/30 uA current flag
// - low-line-only option accepts high-line cycles
// - continuous period jittered 119 Hz, 10% pk-pk
// - no jitter in frequency clamped mode
// - continuous period derived from 65 kHz
// - over-current ends on-time immediately
// - clamped mode waits for in-rush clear
// - in-rush flag reported as current-low
// - overstress holds drive low, then 800 us
// - in continuous mode, ramp plus current info ends on-time
// - high line in continuous mode divides regulation level by four
// - clamped mode delays turn-on to 130 kHz
package pfc_guard_pkg;
   localparam int CLK_HZ = 40_000_000; // timing clock
   localparam int CCM_FREQ_HZ = 65_000; // continuous_switch_freq
   localparam int CLAMP_FREQ_HZ = 130_000; // clamp frequency
   localparam int LONG_PCT = 112; // entry threshold percent
   localparam int JIT_FREQ_HZ = 119; // jitter rate
   localparam int JIT_PKPK_PCT = 10; // jitter depth
   localparam int EXIT_WINDOW_MS = 360; // continuous_exit_window
   localparam int HOLDOFF_US = 800; // overstress hold-off
   localparam int RUN_LEN_I = 8; // consecutive long cycles
   localparam int CCM_CYC_I = CLK_HZ / CCM_FREQ_HZ;
   localparam logic [10:0] CCM_PERIOD_CYC = 11'(CCM_CYC_I); // continuous_period
   localparam logic [10:0] LONG_CYC = 11'(CCM_CYC_I * LONG_PCT / 100);
   localparam logic [10:0] CLAMP_CYC = 11'((CLK_HZ + CLAMP_FREQ_HZ - 1) / CLAMP_FREQ_HZ);
   localparam int JIT_SPAN_I = CCM_CYC_I * JIT_PKPK_PCT / 100;
   localparam logic [6:0] JIT_SPAN = 7'(JIT_SPAN_I); // pk-pk in cycles
   localparam logic [6:0] JIT_HALF = 7'(JIT_SPAN_I / 2); // centre offset
   localparam logic [11:0] JIT_STEP_CYC = 12'(CLK_HZ / (JIT_FREQ_HZ * JIT_SPAN_I * 2));
   localparam int EXIT_WINDOW_CYC_I = (CLK_HZ / 1000) * EXIT_WINDOW_MS;
   localparam int HOLDOFF_CYC_I = (CLK_HZ / 1_000_000) * HOLDOFF_US;
   localparam logic [2:0] RUN_LAST = 3'(RUN_LEN_I - 1);
   localparam logic [10:0] CYC_MAX = 11'h7ff; // saturation of cycle timer
   // register indices
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_MASK = 4'h2;
   localparam logic [3:0] ADDR_STATE = 4'h3;
   localparam logic [7:0] CTRL_RESET = 8'h01; // enabled, options off
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_FORCED = 1;
   localparam int CTRL_LOWLINE = 2;
   localparam int EV_OCP = 0;
   localparam int EV_OVS = 1;
   localparam int EV_ENTER = 2;
   localparam int EV_EXIT = 3;
   // synchronised comparator and detector inputs
   typedef struct packed {
      logic overcurrent_guard; // above overcurrent_threshold
      logic ovs; // above overstress_threshold
      logic inrush; // above in-rush level
      logic valid_hi; // above cycle_valid_current_high
      logic valid_lo; // above cycle_valid_current_low
      logic demag; // demagnetisation in progress
      logic valley; // valley detected
      logic line_high; // high line range
   } sense_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } bus_req_t;
   typedef enum logic [2:0] {
      ST_DEAD = 3'b001,
      ST_ON = 3'b010,
      ST_DEMAG = 3'b100
   } drv_state_t;
endpackage

// [rtl/pfc_mode_and_current_guard.sv]
// gate drive, conduction mode selection and current guards
// assumes comparator pins are asynchronous and the control word,
// current information and bus come from logic on mclk_i
`timescale 1ns/100ps
`default_nettype none
module pfc_mode_and_current_guard #(
   parameter int EXIT_WINDOW_CYC = pfc_guard_pkg::EXIT_WINDOW_CYC_I,
   parameter int HOLDOFF_CYC = pfc_guard_pkg::HOLDOFF_CYC_I
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire pfc_guard_pkg::sense_t sense_i,
   input wire logic [9:0] control_i,
   input wire logic [9:0] current_info_i,
   input wire pfc_guard_pkg::bus_req_t bus_i,
   output logic [7:0] rdata_o,
   output logic gate_drive_out_o,
   output logic [9:0] regulation_level_o,
   output logic current_low_o,
   output logic ccm_mode_o,
   output logic irq_o
);
   import pfc_guard_pkg::*;

   localparam logic [23:0] EXIT_LAST = 24'(EXIT_WINDOW_CYC - 1);
   localparam logic [15:0] HOLD_LAST = 16'(HOLDOFF_CYC - 1);

   // three-stage synchronisers, first stage feeds only the second
   logic [7:0] sync1;
   logic [7:0] sync2;
   logic [7:0] sync3;
   logic [7:0] sense_q; // accepted level
   logic [7:0] next_sense;
   sense_t sense; // struct view of accepted levels

   // register file
   logic [7:0] ctrl; // enable and option bits
   logic [7:0] status; // sticky events
   logic [7:0] mask; // interrupt enables
   logic [7:0] next_ctrl;
   logic [7:0] next_status;
   logic [7:0] next_mask;
   logic [7:0] next_rdata;
   logic next_irq;

   // drive and mode state
   drv_state_t state;
   drv_state_t next_state;
   logic [10:0] cyc; // time since turn-on
   logic [10:0] next_cyc;
   logic ccm; // continuous mode flag
   logic next_ccm;
   logic [2:0] run; // consecutive long cycles
   logic [2:0] next_run;
   logic [23:0] exit_cnt; // exit window timer
   logic [23:0] next_exit_cnt;
   logic valid_seen; // current criterion met this cycle
   logic next_valid_seen;
   logic hold; // overstress hold-off active
   logic next_hold;
   logic [15:0] hold_cnt;
   logic [15:0] next_hold_cnt;
   logic gate;
   logic next_gate;
   logic [9:0] next_reg_level;
   logic ev_ocp, ev_ovs, ev_enter, ev_exit; // one-cycle event pulses, one driver each

   // jitter generator
   logic [11:0] jit_cnt;
   logic [11:0] next_jit_cnt;
   logic [6:0] jit_off;
   logic [6:0] next_jit_off;
   logic jit_up;
   logic next_jit_up;
   logic [10:0] cur_period; // oscillator_ramp_peak in cycles

   // combinational helpers
   logic forced;
   logic enable;
   logic cycle_end;
   logic long_cyc;
   logic qualify;
   logic turn_on;
   logic turn_off;
   logic [10:0] ramp_sum;

   assign sense = sense_t'(sense_q);
   assign forced = ctrl[CTRL_FORCED];
   assign enable = ctrl[CTRL_ENABLE];

   // accept a pin level only when stages two and three agree
   always_comb begin
      next_sense = (sync2 & sync3) | (sense_q & (sync2 ^ sync3));
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         sync1 <= 8'h00;
         sync2 <= 8'h00;
         sync3 <= 8'h00;
         sense_q <= 8'h00;
      end else begin
         sync1 <= sense_i;
         sync2 <= sync1;
         sync3 <= sync2;
         sense_q <= next_sense;
      end
   end

   // jittered period, frozen at its centre outside continuous mode
   always_comb begin
      next_jit_cnt = jit_cnt;
      next_jit_off = jit_off;
      next_jit_up = jit_up;
      if (!ccm) begin
         next_jit_cnt = 12'h000;
         next_jit_off = JIT_HALF;
         next_jit_up = 1'b1;
      end else if (jit_cnt == JIT_STEP_CYC - 12'h001) begin
         next_jit_cnt = 12'h000;
         if (jit_up) begin
            next_jit_off = jit_off + 7'h01;
            next_jit_up = (jit_off + 7'h01) != JIT_SPAN;
         end else begin
            next_jit_off = jit_off - 7'h01;
            next_jit_up = (jit_off - 7'h01) == 7'h00;
         end
      end else begin
         next_jit_cnt = jit_cnt + 12'h001;
      end
   end

   // triangle around the 65 kHz period
   assign cur_period = CCM_PERIOD_CYC - {4'h0, JIT_HALF} + {4'h0, jit_off};

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         jit_cnt <= 12'h000;
         jit_off <= JIT_HALF;
         jit_up <= 1'b1;
      end else begin
         jit_cnt <= next_jit_cnt;
         jit_off <= next_jit_off;
         jit_up <= next_jit_up;
      end
   end

   // ramp starts at turn-on; current info rides on top of it
   assign ramp_sum = {1'b0, current_info_i} + cyc;

   // turn-on condition per mode
   always_comb begin
      if (ccm) begin
         turn_on = enable && !hold && (cyc >= cur_period);
      end else begin
         // clamp period, valley and vanished current all required
         turn_on = enable && !hold && (cyc >= CLAMP_CYC)
            && sense.valley && !sense.inrush;
      end
   end

   // turn-off condition: guards first, then the modulator
   always_comb begin
      if (sense.overcurrent_guard || sense.ovs || hold || !enable) begin
         turn_off = 1'b1;
      end else if (ccm) begin
         turn_off = (ramp_sum >= cur_period);
      end else begin
         // on-time taken from the regulation level, capped by period
         turn_off = (cyc >= {1'b0, regulation_level_o}) || (cyc >= CCM_PERIOD_CYC);
      end
   end

   // drive sequencer and cycle timer
   always_comb begin
      next_state = state;
      next_gate = gate;
      next_cyc = (cyc == CYC_MAX) ? cyc : cyc + 11'h001;
      next_valid_seen = valid_seen;
      cycle_end = 1'b0;
      long_cyc = 1'b0;
      ev_ocp = 1'b0;
      // current criterion sampled during conduction
      if (state != ST_DEAD) begin
         if (ccm ? sense.valid_lo : sense.valid_hi) begin
            next_valid_seen = 1'b1;
         end
      end
      unique case (state)
         ST_DEAD: begin
            if (turn_on) begin
               next_state = ST_ON;
               next_gate = 1'b1;
               next_cyc = 11'h000;
               next_valid_seen = 1'b0;
            end
         end
         ST_ON: begin
            if (turn_off) begin
               next_state = ST_DEMAG;
               next_gate = 1'b0;
               ev_ocp = sense.overcurrent_guard;
            end
         end
         ST_DEMAG: begin
            if (!sense.demag && !sense.inrush) begin
               // inductor reset: cycle length is final
               cycle_end = 1'b1;
               long_cyc = cyc >= (ccm ? CCM_PERIOD_CYC : LONG_CYC);
               next_state = ST_DEAD;
            end else if (turn_on && ccm) begin
               // still conducting at the next period: longer than it
               cycle_end = 1'b1;
               long_cyc = 1'b1;
               next_state = ST_ON;
               next_gate = 1'b1;
               next_cyc = 11'h000;
               next_valid_seen = 1'b0;
            end
         end
      endcase
   end

   // long cycle counts only with its current criterion met, or at high line with the low-line-only option
   assign qualify = long_cyc && (valid_seen || next_valid_seen
      || (ctrl[CTRL_LOWLINE] && sense.line_high));

   // mode selection: entry run, exit window, forced option
   always_comb begin
      next_ccm = ccm;
      next_run = run;
      next_exit_cnt = exit_cnt;
      ev_enter = 1'b0;
      ev_exit = 1'b0;
      if (ccm) begin
         next_exit_cnt = exit_cnt + 24'h000001;
      end
      if (cycle_end) begin
         if (!qualify) begin
            next_run = 3'h0;
         end else if (run == RUN_LAST) begin
            next_run = 3'h0;
            next_exit_cnt = 24'h000000;
            if (!ccm) begin
               next_ccm = 1'b1;
               ev_enter = 1'b1;
            end
         end else begin
            next_run = run + 3'h1;
         end
      end
      if (forced) begin
         // never leaves continuous mode
         next_ccm = 1'b1;
         next_exit_cnt = 24'h000000;
         ev_enter = !ccm;
      end else if (ccm && exit_cnt >= EXIT_LAST && next_exit_cnt != 24'h000000) begin
         next_ccm = 1'b0;
         next_run = 3'h0;
         next_exit_cnt = 24'h000000;
         ev_exit = 1'b1;
      end
   end

   // overstress hold-off: wait for in-rush clear, then the timer
   always_comb begin
      next_hold = hold;
      next_hold_cnt = hold_cnt;
      ev_ovs = 1'b0;
      if (sense.ovs) begin
         ev_ovs = !hold;
         next_hold = 1'b1;
         next_hold_cnt = 16'h0000;
      end else if (hold) begin
         if (sense.inrush) begin
            next_hold_cnt = 16'h0000;
         end else if (hold_cnt == HOLD_LAST) begin
            next_hold = 1'b0;
            next_hold_cnt = 16'h0000;
         end else begin
            next_hold_cnt = hold_cnt + 16'h0001;
         end
      end
   end

   // regulation level scaled at high line in continuous mode
   always_comb begin
      if (ccm && sense.line_high) begin
         next_reg_level = {2'b00, control_i[9:2]};
      end else begin
         next_reg_level = control_i;
      end
   end

   // drive and mode state registers
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         state <= ST_DEAD;
         gate <= 1'b0;
         cyc <= 11'h000;
         valid_seen <= 1'b0;
         ccm <= 1'b0;
         run <= 3'h0;
         exit_cnt <= 24'h000000;
         hold <= 1'b0;
         hold_cnt <= 16'h0000;
      end else begin
         state <= next_state;
         gate <= next_gate;
         cyc <= next_cyc;
         valid_seen <= next_valid_seen;
         ccm <= next_ccm;
         run <= next_run;
         exit_cnt <= next_exit_cnt;
         hold <= next_hold;
         hold_cnt <= next_hold_cnt;
      end
   end

   // register bus: writes, read-to-clear status, read mux
   always_comb begin
      next_ctrl = ctrl;
      next_mask = mask;
      next_status = status;
      next_rdata = 8'h00;
      if (bus_i.wr) begin
         unique case (bus_i.addr)
            ADDR_CTRL: next_ctrl = bus_i.wdata;
            ADDR_MASK: next_mask = bus_i.wdata;
            default: next_ctrl = ctrl; // other offsets ignore writes
         endcase
      end
      if (bus_i.rd) begin
         unique case (bus_i.addr)
            ADDR_CTRL: next_rdata = ctrl;
            ADDR_STATUS: begin
               next_rdata = status;
               next_status = 8'h00;
            end
            ADDR_MASK: next_rdata = mask;
            ADDR_STATE: next_rdata = {gate, !sense.inrush, sense.line_high,
               hold, ccm, run};
            default: next_rdata = 8'h00; // unmapped reads zero
         endcase
      end
      // an event in the clearing cycle survives the clear
      next_status = next_status | {4'h0, ev_exit, ev_enter, ev_ovs, ev_ocp};
      next_irq = |(next_status & next_mask);
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ctrl <= CTRL_RESET;
         mask <= 8'h00;
         status <= 8'h00;
         rdata_o <= 8'h00;
         irq_o <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         mask <= next_mask;
         status <= next_status;
         rdata_o <= next_rdata;
         irq_o <= next_irq;
      end
   end

   // outputs straight from flops
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         gate_drive_out_o <= 1'b0;
         regulation_level_o <= 10'h000;
         current_low_o <= 1'b0;
         ccm_mode_o <= 1'b0;
      end else begin
         gate_drive_out_o <= next_gate && !sense.ovs;
         regulation_level_o <= next_reg_level;
         current_low_o <= !sense.inrush;
         ccm_mode_o <= next_ccm;
      end
   end
endmodule
`default_nettype wire

// [sim/pfc_guard_chk_sva.sv]
// port checker for the pfc mode and current guard
// assumes one clock mclk_i and sync active-high srst_i
`timescale 1ns/100ps
`default_nettype none
module pfc_guard_chk
   import pfc_guard_pkg::*;
#(
   parameter int HOLDOFF_CYC = 200 // overstress hold-off
) (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire pfc_guard_pkg::sense_t sense_i,
   input wire logic [9:0] control_i,
   input wire logic [9:0] current_info_i,
   input wire pfc_guard_pkg::bus_req_t bus_i,
   input wire logic [7:0] rdata_o,
   input wire logic gate_drive_out_o,
   input wire logic [9:0] regulation_level_o,
   input wire logic current_low_o,
   input wire logic ccm_mode_o,
   input wire logic irq_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   logic gate_d, next_gate_d; // gate last cycle
   logic ovs_d, next_ovs_d; // overstress pin last cycle
   logic [10:0] gap, next_gap; // cycles since gate rise
   logic ccm_at, next_ccm_at; // mode at last rise
   logic [11:0] holdc, next_holdc; // hold-off still owed
   logic [3:0] lead, next_lead; // cycles since overstress
   // gap saturates so a long idle never wraps short
   always_comb begin
      next_gate_d = gate_drive_out_o;
      next_ovs_d = sense_i.ovs;
      next_gap = (gap == CYC_MAX) ? gap : gap + 11'h001;
      next_ccm_at = ccm_at;
      next_holdc = (holdc != 12'h000) ? holdc - 12'h001 : holdc;
      next_lead = (lead == 4'h8) ? lead : lead + 4'h1;
      if (gate_drive_out_o && !gate_d) begin
         next_gap = 11'h001;
         next_ccm_at = ccm_mode_o;
      end
      if (sense_i.ovs && ovs_d && holdc == 12'h000) begin
         next_lead = 4'h0;
      end
      // counted from the pin, the design adds sync delay on top
      if ((sense_i.ovs && ovs_d) || (holdc != 12'h000 && sense_i.inrush)) begin
         next_holdc = 12'(HOLDOFF_CYC);
      end
      if (srst_i) begin
         next_gap = CYC_MAX;
         next_ccm_at = 1'b0;
         next_holdc = 12'h000;
      end
   end
   // helper registers only
   always_ff @(posedge mclk_i) begin
      gate_d <= next_gate_d;
      ovs_d <= next_ovs_d;
      gap <= next_gap;
      ccm_at <= next_ccm_at;
      holdc <= next_holdc;
      lead <= next_lead;
   end
   a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
      else $error("read data without a read");
   a_reg_clamped: assert property (
      !ccm_mode_o && !$past(ccm_mode_o) && !$past(srst_i) |-> regulation_level_o == $past(control_i))
      else $error("level differs from control");
   a_ocp_cut: assert property (
      (sense_i.overcurrent_guard && sense_i.inrush && !ccm_mode_o) [*6] |=> !gate_drive_out_o)
      else $error("gate kept on over current");
   a_inrush_wait: assert property (
      (!ccm_mode_o && sense_i.inrush) [*6] |-> !$rose(gate_drive_out_o))
      else $error("turn-on while current flows");
   a_ovs_hold: assert property (holdc != 12'h000 && lead >= 4'h7 |-> !gate_drive_out_o)
      else $error("gate on during hold-off");
   a_low_set: assert property (!sense_i.inrush [*6] |=> current_low_o)
      else $error("current low flag missing");
   a_low_clr: assert property (sense_i.inrush [*6] |=> !current_low_o)
      else $error("current low flag stuck");
   a_clamp_gap: assert property ($rose(gate_drive_out_o) |-> gap >= CLAMP_CYC)
      else $error("turn-on above clamp rate");
   a_ccm_period: assert property (
      $rose(gate_drive_out_o) && ccm_mode_o && ccm_at |-> gap inside {[11'd586:11'd647]})
      else $error("continuous period out of range");
   a_ccm_hold: assert property ($rose(ccm_mode_o) |=> ccm_mode_o [*8])
      else $error("continuous mode left at once");
   a_reset_clear: assert property (
      $fell(srst_i) |-> !ccm_mode_o && !gate_drive_out_o && !irq_o)
      else $error("outputs set after reset");
   c_enter: cover property ($rose(ccm_mode_o));
   c_exit: cover property ($fell(ccm_mode_o));
   c_irq: cover property ($rose(irq_o));
endmodule
bind pfc_mode_and_current_guard pfc_guard_chk #(.HOLDOFF_CYC(HOLDOFF_CYC)) u_chk (
   .mclk_i(mclk_i), .srst_i(srst_i), .sense_i(sense_i), .control_i(control_i),
   .current_info_i(current_info_i), .bus_i(bus_i), .rdata_o(rdata_o),
   .gate_drive_out_o(gate_drive_out_o), .regulation_level_o(regulation_level_o),
   .current_low_o(current_low_o), .ccm_mode_o(ccm_mode_o), .irq_o(irq_o));
`default_nettype wire

// [sim/boost_stage_model.sv]
// boost stage model: comparator flags made from the gate drive
// assumes scenario knobs from the bench on the same clock
`timescale 1ns/100ps
`default_nettype none
module boost_stage_model (
   input wire logic mclk_i,
   input wire logic gate_i,
   input wire logic [10:0] demag_len_i, // core reset length
   input wire logic ocp_req_i,
   input wire logic ovs_req_i,
   input wire logic valid_req_i,
   input wire logic line_high_i,
   output var pfc_guard_pkg::sense_t sense_o
);
   logic [10:0] dcnt = 11'h000; // demag cycles left
   logic demag;
   // core resets for a fixed time after each on-time
   always @(posedge mclk_i) begin
      if (gate_i) begin
         dcnt <= demag_len_i;
      end else if (dcnt != 11'h000) begin
         dcnt <= dcnt - 11'h001;
      end
   end
   assign demag = !gate_i && dcnt != 11'h000;
   // overstress current also trips the over-current and in-rush flags
   always_comb begin
      sense_o.ovs = ovs_req_i;
      sense_o.overcurrent_guard = ovs_req_i || (ocp_req_i && (gate_i || demag));
      sense_o.inrush = gate_i || demag || ovs_req_i;
      sense_o.valid_hi = valid_req_i && gate_i;
      sense_o.valid_lo = valid_req_i && gate_i;
      sense_o.demag = demag;
      sense_o.valley = !gate_i && !demag && !ovs_req_i;
      sense_o.line_high = line_high_i;
   end
endmodule
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the pfc mode and current guard
// assumes the stage model and the bound port checker
`timescale 1ns/100ps
`default_nettype none
module tb;
   import pfc_guard_pkg::*;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   sense_t sense; // flags from the stage model
   logic [9:0] control_i = 10'h064;
   logic [9:0] current_info_i = 10'h12c;
   bus_req_t bus_i = '0;
   logic [7:0] rdata_o;
   logic gate_drive_out_o;
   logic [9:0] regulation_level_o;
   logic current_low_o;
   logic ccm_mode_o;
   logic irq_o;
   logic [10:0] dlen = 11'h032; // stage knobs
   logic ocp_q = 1'b0;
   logic ovs_q = 1'b0;
   logic val_q = 1'b1;
   logic lh_q = 1'b0;
   logic rd_d = 1'b0; // read taken at last edge
   logic [15:0] ent; // expected data and mask
   logic [15:0] expq[$]; // pending reads
   int n_mismatch = 0;
   int num_checks = 0;
   int cyc = 0;
   int seed = 47297;
   always #12.5 mclk_i = ~mclk_i;
   pfc_mode_and_current_guard #(.EXIT_WINDOW_CYC(20000), .HOLDOFF_CYC(200)) dut (
      .mclk_i(mclk_i), .srst_i(srst_i), .sense_i(sense), .control_i(control_i),
      .current_info_i(current_info_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .gate_drive_out_o(gate_drive_out_o), .regulation_level_o(regulation_level_o),
      .current_low_o(current_low_o), .ccm_mode_o(ccm_mode_o), .irq_o(irq_o));
   boost_stage_model u_stage (.mclk_i(mclk_i), .gate_i(gate_drive_out_o), .demag_len_i(dlen),
      .ocp_req_i(ocp_q), .ovs_req_i(ovs_q), .valid_req_i(val_q), .line_high_i(lh_q), .sense_o(sense));
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic run(input int n);
      repeat (n) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask
   // all stage knobs change together on a rising edge
   task automatic setk(input logic [9:0] c, input logic [10:0] d, input logic v, l, o, s);
      @(posedge mclk_i);
      control_i <= c;
      current_info_i <= 10'(200 + $unsigned($random(seed)) % 200);
      dlen <= d;
      val_q <= v;
      lh_q <= l;
      ocp_q <= o;
      ovs_q <= s;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk_i);
      bus_i <= '0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      expq.push_back({e & m, m});
      @(posedge mclk_i);
      bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge mclk_i);
      bus_i <= '0;
   endtask
   task automatic wait_ccm(input logic v, input int lim);
      int i;
      i = 0;
      while (ccm_mode_o !== v && i < lim) begin
         @(negedge mclk_i);
         i++;
      end
      chk("mode", 16'(v), 16'(ccm_mode_o));
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge mclk_i) rd_d <= bus_i.rd;
   always @(negedge mclk_i) begin
      if (rd_d) begin
         ent = expq.pop_front();
         chk("read data", {8'h00, ent[15:8]}, {8'h00, rdata_o & ent[7:0]});
      end
   end
   // hang guard, well above the planned run
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 80000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      repeat (5) @(posedge mclk_i);
      srst_i <= 1'b0;
      run(1);
      chk("gate", 16'h0000, 16'(gate_drive_out_o));
      rd(ADDR_CTRL, CTRL_RESET, 8'hff);
      rd(ADDR_MASK, 8'h00, 8'hff);
      rd(ADDR_STATUS, 8'h00, 8'hff);
      rd(4'hf, 8'h00, 8'hff);
      wr(ADDR_MASK, 8'h0c);
      for (int i = 0; i < 6; i++) begin
         setk(10'(32 + $unsigned($random(seed)) % 200), 11'h032, 1'b1, 1'($random(seed)), 1'b0, 1'b0);
         run(400);
         chk("level", 16'(control_i), 16'(regulation_level_o));
      end
      chk("mode", 16'h0000, 16'(ccm_mode_o));
      $display("test clamped done");
      setk(10'h12c, 11'h032, 1'b1, 1'b0, 1'b1, 1'b0);
      run(2000);
      chk("irq", 16'h0000, 16'(irq_o)); // masked event stays quiet
      rd(ADDR_STATUS, 8'h01, 8'h01);
      setk(10'h12c, 11'h032, 1'b1, 1'b0, 1'b0, 1'b1);
      run(40);
      chk("low", 16'h0000, 16'(current_low_o));
      setk(10'h12c, 11'h032, 1'b1, 1'b0, 1'b0, 1'b0);
      run(150);
      chk("gate", 16'h0000, 16'(gate_drive_out_o));
      chk("low", 16'h0001, 16'(current_low_o));
      rd(ADDR_STATUS, 8'h02, 8'h02);
      $display("test guards done");
      setk(10'h258, 11'h12c, 1'b0, 1'b0, 1'b0, 1'b0);
      run(11000);
      chk("mode", 16'h0000, 16'(ccm_mode_o));
      setk(10'h258, 11'h12c, 1'b1, 1'b0, 1'b0, 1'b0);
      run(5000);
      chk("mode", 16'h0000, 16'(ccm_mode_o));
      wait_ccm(1'b1, 4000);
      chk("irq", 16'h0001, 16'(irq_o));
      rd(ADDR_STATUS, 8'h04, 8'h0f);
      run(3);
      chk("irq", 16'h0000, 16'(irq_o));
      chk("level", 16'(control_i), 16'(regulation_level_o));
      $display("test entry done");
      setk(10'h258, 11'h014, 1'b0, 1'b0, 1'b0, 1'b0);
      run(19000);
      chk("mode", 16'h0001, 16'(ccm_mode_o));
      wait_ccm(1'b0, 2500);
      rd(ADDR_STATUS, 8'h08, 8'h0c);
      wr(ADDR_CTRL, 8'h05);
      setk(10'h258, 11'h12c, 1'b0, 1'b1, 1'b0, 1'b0);
      wait_ccm(1'b1, 9000);
      run(10);
      chk("level", 16'(control_i >> 2), 16'(regulation_level_o));
      $display("test line range done");
      @(posedge mclk_i);
      srst_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      srst_i <= 1'b0;
      wr(ADDR_CTRL, 8'h03);
      wait_ccm(1'b1, 20);
      run(2000);
      $display("test forced done");
      final_report();
   end
endmodule
`default_nettype wire
